/* hw/operand_address_generator.sv */
// Operand effective-address generator for the 8-bit core
// Behaviour
// RQ1: Direct form uses the 16-bit immediate field unchanged as the address.
// RQ2: Short direct form reaches only the 256-byte window FE20H to FF1FH via an 8-bit field.
// RQ3: Short direct bit 8 is cleared for fields 20H to FFH and set for 00H to 1FH.
// RQ4: Short window FE20H-FEFFH goes to high-speed RAM and FF00H-FF1FH to special registers.
// RQ5: Word operands in short direct form must be even and inside the window (odd ones raise fault).
// RQ6: Special register form maps an 8-bit field onto FF00H-FFCFH and FFE0H-FFFFH only.
// RQ7: Byte register form picks one of eight byte registers by a 3-bit code.
// RQ8: Eight byte registers 0-7 and four register pairs 0-3 are selectable by code.
// RQ9: Register indirect uses the whole first or second pointer pair as the address.
// RQ10: Based form adds the zero-extended offset to the second pointer pair, dropping carry.
// RQ11: Push, pop, call, return and interrupt save/restore address through the stack pointer.
// RQ12: Stack accesses reach only the high-speed RAM area.
`timescale 1ns/1ns
`default_nettype none
module operand_address_generator (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Decoded operand request
    input wire logic req_valid,
    input wire oag_pkg::request_t req,
    // Register pair contents
    input wire logic [15:0] pointer_pair_one,
    input wire logic [15:0] pointer_pair_two,
    input wire logic [15:0] stack_pointer_reg,
    // Registered operand selection
    output oag_pkg::result_t res
);
    // ==========================================
    // Reset release
    // Asserts at once, release retimed to the clock
    logic rst_n;

    sync_bit u_rst (
        .clk(clk),
        .nrst(nrst),
        .q(rst_n)
    );

    // ==========================================
    // Result state
    typedef struct packed {
        oag_pkg::result_t res;
    } st_t;
    st_t st_q;
    st_t st_d;

    // ==========================================
    // Address formation
    always_comb begin
        logic [15:0] a;
        logic [15:0] ptr;
        a = '0;
        // Pointer picked up front; only the indirect arm reads it
        ptr = req.indirect_sel ? pointer_pair_two : pointer_pair_one;
        st_d = st_q;
        st_d.res = '0;
        st_d.res.valid = req_valid;
        st_d.res.wide = req.wide;
        unique case (req.mode)
            oag_pkg::MODE_DIRECT: begin
                a = req.full_address_field; // RQ1
                // Page FFxx holds special registers, all below is memory
                st_d.res.target = (a >= oag_pkg::SFR_BASE) ? oag_pkg::TGT_SFR : oag_pkg::TGT_RAM;
                st_d.res.addr = a;
            end
            oag_pkg::MODE_SHORT: begin
                a = {oag_pkg::SHORT_BASE[15:9], 1'b0, req.byte_field}; // RQ2
                // Low 32 fields fold onto the special register page
                a[oag_pkg::ADDR_BIT8] = (req.byte_field < oag_pkg::SHORT_WRAP); // RQ3
                st_d.res.addr = a;
                st_d.res.target = (a <= oag_pkg::RAM_HI) ? oag_pkg::TGT_RAM : oag_pkg::TGT_SFR; // RQ4
                st_d.res.fault = req.wide & a[0]; // RQ5
            end
            oag_pkg::MODE_SFR: begin
                a = {oag_pkg::SFR_BASE[15:8], req.byte_field}; // RQ6
                st_d.res.addr = a;
                // No register sits in the gap slice, so flag it
                if (a >= oag_pkg::SFR_GAP_LO && a <= oag_pkg::SFR_GAP_HI) begin // RQ6
                    st_d.res.target = oag_pkg::TGT_NONE;
                    st_d.res.fault = 1'b1;
                end else begin
                    st_d.res.target = oag_pkg::TGT_SFR;
                end
            end
            oag_pkg::MODE_REG8: begin
                st_d.res.target = oag_pkg::TGT_REG;
                st_d.res.reg_sel = req.reg_code; // RQ7 RQ8
            end
            oag_pkg::MODE_REG16: begin
                st_d.res.target = oag_pkg::TGT_REG;
                st_d.res.pair_sel = req.register_pair_select; // RQ8
                // A pair is always a word, whatever the request says
                st_d.res.wide = 1'b1;
            end
            oag_pkg::MODE_INDIRECT: begin
                a = ptr; // RQ9
                st_d.res.addr = a;
                st_d.res.target = (a >= oag_pkg::SFR_BASE) ? oag_pkg::TGT_SFR : oag_pkg::TGT_RAM;
            end
            oag_pkg::MODE_BASED: begin
                // 16-bit sum, carry out of bit 15 falls away
                a = pointer_pair_two + {8'h00, req.byte_field}; // RQ10
                st_d.res.addr = a;
                st_d.res.target = (a >= oag_pkg::SFR_BASE) ? oag_pkg::TGT_SFR : oag_pkg::TGT_RAM;
            end
            oag_pkg::MODE_STACK: begin
                a = stack_pointer_reg; // RQ11
                st_d.res.addr = a;
                // Stack outside fast RAM is blocked rather than wrapped
                if (a >= oag_pkg::STACK_RAM_LO && a <= oag_pkg::STACK_RAM_HI) begin // RQ12
                    st_d.res.target = oag_pkg::TGT_RAM;
                end else begin
                    st_d.res.target = oag_pkg::TGT_NONE;
                    st_d.res.fault = 1'b1;
                end
            end
        endcase
        // Idle cycles give an all-zero result so no stale target lingers
        if (!req_valid) begin
            st_d.res = '0;
        end
    end

    // ==========================================
    // Result register
    // Only the result is held; request fields are used as they arrive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign res = st_q.res;

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Idle cycles must leave nothing behind
    idle_zero_a: assert property (!req_valid
        |=> res == '0) else $error("idle result not clear");
    // Memory forms
    direct_pass_a: assert property (req_valid && req.mode == oag_pkg::MODE_DIRECT // RQ1
        |=> res.valid && res.addr == $past(req.full_address_field)) else $error("direct address altered");
    direct_target_a: assert property (req_valid && req.mode == oag_pkg::MODE_DIRECT // RQ1
        && req.full_address_field < oag_pkg::SFR_BASE |=> res.target == oag_pkg::TGT_RAM)
        else $error("direct target wrong");
    short_window_a: assert property (req_valid && req.mode == oag_pkg::MODE_SHORT // RQ2
        |=> res.addr >= oag_pkg::SHORT_LO && res.addr <= oag_pkg::SHORT_HI) else $error("short outside window");
    short_bit8_a: assert property (req_valid && req.mode == oag_pkg::MODE_SHORT // RQ3
        |=> res.addr[oag_pkg::ADDR_BIT8] == ($past(req.byte_field) < oag_pkg::SHORT_WRAP)
        && res.addr[7:0] == $past(req.byte_field)) else $error("short bit 8 wrong");
    short_target_a: assert property (res.valid && res.addr >= oag_pkg::SFR_BASE // RQ4
        && res.addr <= oag_pkg::SHORT_HI && $past(req.mode) == oag_pkg::MODE_SHORT |-> res.target == oag_pkg::TGT_SFR)
        else $error("short sfr target wrong");
    short_ram_a: assert property (req_valid && req.mode == oag_pkg::MODE_SHORT // RQ4
        && req.byte_field >= oag_pkg::SHORT_WRAP |=> res.target == oag_pkg::TGT_RAM)
        else $error("short ram target wrong");
    short_even_a: assert property (req_valid && req.mode == oag_pkg::MODE_SHORT && req.wide // RQ5
        && req.byte_field[0] |=> res.fault) else $error("odd word not flagged");
    short_clean_a: assert property (req_valid && req.mode == oag_pkg::MODE_SHORT // RQ5
        && !(req.wide && req.byte_field[0]) |=> !res.fault) else $error("even word flagged");
    sfr_range_a: assert property (res.valid && res.target == oag_pkg::TGT_SFR // RQ6
        && $past(req.mode) == oag_pkg::MODE_SFR
        |-> res.addr >= oag_pkg::SFR_BASE
        && !(res.addr inside {[oag_pkg::SFR_GAP_LO:oag_pkg::SFR_GAP_HI]})) else $error("sfr range");
    sfr_gap_a: assert property (req_valid && req.mode == oag_pkg::MODE_SFR // RQ6
        && {oag_pkg::SFR_BASE[15:8], req.byte_field} inside {[oag_pkg::SFR_GAP_LO:oag_pkg::SFR_GAP_HI]}
        |=> res.fault && res.target == oag_pkg::TGT_NONE) else $error("sfr gap reachable");
    sfr_addr_a: assert property (req_valid && req.mode == oag_pkg::MODE_SFR // RQ6
        |=> res.addr == {oag_pkg::SFR_BASE[15:8], $past(req.byte_field)}) else $error("sfr address");

    // Register forms
    reg_sel_a: assert property (req_valid && req.mode == oag_pkg::MODE_REG8 // RQ7
        |=> res.target == oag_pkg::TGT_REG && res.reg_sel == $past(req.reg_code)) else $error("reg select");
    pair_sel_a: assert property (req_valid && req.mode == oag_pkg::MODE_REG16 // RQ8
        |=> res.wide && res.pair_sel == $past(req.register_pair_select)) else $error("pair select");
    pair_target_a: assert property (req_valid && req.mode == oag_pkg::MODE_REG16 // RQ8
        |=> res.target == oag_pkg::TGT_REG) else $error("pair target");

    // Pointer and stack forms
    indirect_ptr_a: assert property (req_valid && req.mode == oag_pkg::MODE_INDIRECT // RQ9
        |=> res.addr == ($past(req.indirect_sel) ? $past(pointer_pair_two) : $past(pointer_pair_one)))
        else $error("indirect address");
    based_sum_a: assert property (req_valid && req.mode == oag_pkg::MODE_BASED // RQ10
        |=> res.addr == 16'($past(pointer_pair_two) + 16'($past(req.byte_field)))) else $error("based sum");
    stack_sp_a: assert property (req_valid && req.mode == oag_pkg::MODE_STACK // RQ11
        |=> res.addr == $past(stack_pointer_reg)) else $error("stack address");
    indirect_sfr_a: assert property (req_valid && req.mode == oag_pkg::MODE_INDIRECT // RQ9
        && (req.indirect_sel ? pointer_pair_two : pointer_pair_one) >= oag_pkg::SFR_BASE
        |=> res.target == oag_pkg::TGT_SFR) else $error("indirect target");
    based_ram_a: assert property (req_valid && req.mode == oag_pkg::MODE_BASED // RQ10
        && 16'(pointer_pair_two + 16'(req.byte_field)) < oag_pkg::SFR_BASE
        |=> res.target == oag_pkg::TGT_RAM) else $error("based target");
    stack_ram_a: assert property (res.valid && res.target == oag_pkg::TGT_RAM // RQ12
        && $past(req.mode) == oag_pkg::MODE_STACK
        |-> res.addr >= oag_pkg::STACK_RAM_LO && res.addr <= oag_pkg::STACK_RAM_HI)
        else $error("stack outside ram");
    stack_block_a: assert property (req_valid && req.mode == oag_pkg::MODE_STACK // RQ12
        && !(stack_pointer_reg inside {[oag_pkg::STACK_RAM_LO:oag_pkg::STACK_RAM_HI]})
        |=> res.fault && res.target == oag_pkg::TGT_NONE) else $error("stack escape");

    // ==========================================
    // Cover points
    // Each mark is a path the bench has to reach
    short_cov_c: cover property (req_valid && req.mode == oag_pkg::MODE_SHORT ##1 res.target == oag_pkg::TGT_SFR);
    based_wrap_c: cover property (req_valid && req.mode == oag_pkg::MODE_BASED
        && 16'(pointer_pair_two + 16'(req.byte_field)) < pointer_pair_two);
    stack_fault_c: cover property (res.valid && res.fault
        && $past(req.mode) == oag_pkg::MODE_STACK);
    sfr_gap_c: cover property (res.valid && res.target == oag_pkg::TGT_NONE
        && $past(req.mode) == oag_pkg::MODE_SFR);
    pair_sel_c: cover property (req_valid && req.mode == oag_pkg::MODE_REG16
        && req.register_pair_select == oag_pkg::PAIR_PTR2);
endmodule // operand_address_generator
`default_nettype wire

/* hw/oag_pkg.sv */
// Package: constants and types for the operand address generator
package oag_pkg;
    localparam logic [15:0] SHORT_BASE = 16'hFE00;
    localparam logic [15:0] SHORT_LO = 16'hFE20;
    localparam logic [15:0] SHORT_HI = 16'hFF1F;
    localparam logic [15:0] RAM_HI = 16'hFEFF;
    localparam logic [15:0] SFR_BASE = 16'hFF00;
    localparam logic [15:0] SFR_GAP_LO = 16'hFFD0;
    localparam logic [15:0] SFR_GAP_HI = 16'hFFDF;
    localparam logic [7:0] SHORT_WRAP = 8'h20;
    localparam int ADDR_BIT8 = 8;
    localparam logic [15:0] STACK_RAM_LO = 16'hFE20;
    localparam logic [15:0] STACK_RAM_HI = 16'hFEFF;
    localparam logic [2:0] PAIR_ACC = 3'h0;
    localparam logic [1:0] PAIR_PTR1 = 2'h2;
    localparam logic [1:0] PAIR_PTR2 = 2'h3;
    localparam logic [1:0] PAIR_SEL_ACC = 2'h0;

    typedef enum logic [2:0] {
        MODE_DIRECT,
        MODE_SHORT,
        MODE_SFR,
        MODE_REG8,
        MODE_REG16,
        MODE_INDIRECT,
        MODE_BASED,
        MODE_STACK
    } mode_t;

    typedef enum logic [1:0] {
        TGT_NONE,
        TGT_RAM,
        TGT_SFR,
        TGT_REG
    } target_t;

    typedef struct packed {
        mode_t mode;
        logic [15:0] full_address_field;
        logic [7:0] byte_field;
        logic [2:0] reg_code;
        logic [1:0] register_pair_select;
        logic indirect_sel;
        logic wide;
    } request_t;

    typedef struct packed {
        logic valid;
        target_t target;
        logic [15:0] addr;
        logic [2:0] reg_sel;
        logic [1:0] pair_sel;
        logic wide;
        logic fault;
    } result_t;
endpackage : oag_pkg

/* hw/sync_bit.sv */
// Two-flop reset release stage
`timescale 1ns/1ns
`default_nettype none
module sync_bit (
    // Clock and async reset
    input wire logic clk,
    input wire logic nrst,
    // Synchronised output
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } st_t;
    st_t st_q;
    st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = 1'b1;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule // sync_bit
`default_nettype wire

/* verification/operand_store_model.sv */
// Register pair storage that feeds the generator
`timescale 1ns/1ns
`default_nettype none
module operand_store_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Load port
    input wire logic wr,
    input wire logic [1:0] wsel,
    input wire logic [15:0] wdata,
    // Pair contents
    output logic [15:0] p1,
    output logic [15:0] p2,
    output logic [15:0] sp
);
    // =========================================
    // Storage
    // Stack pointer resets inside fast RAM so a stack access is legal at once
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p1 <= 16'h0000;
            p2 <= 16'h0000;
            sp <= 16'hFEFF;
        end else if (wr) begin
            if (wsel == 2'h0) p1 <= wdata;
            if (wsel == 2'h1) p2 <= wdata;
            if (wsel == 2'h2) sp <= wdata;
        end
    end
endmodule // operand_store_model
`default_nettype wire

/* verification/operand_address_generator_bench.sv */
// Self-checking bench for the operand address generator
`timescale 1ns/1ns
`default_nettype none
module operand_address_generator_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    oag_pkg::request_t req = '0;
    logic wr = 1'b0;
    logic [1:0] wsel = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] p1, p2, sp;
    oag_pkg::result_t res;
    int error_cnt = 0;
    int tests_run = 0;
    always #20 clk = ~clk;
    operand_store_model i_operand_store_model (.clk(clk), .nrst(nrst), .wr(wr), .wsel(wsel),
        .wdata(wdata), .p1(p1), .p2(p2), .sp(sp));
    operand_address_generator i_operand_address_generator (.clk(clk), .nrst(nrst),
        .req_valid(req_valid), .req(req), .pointer_pair_one(p1), .pointer_pair_two(p2),
        .stack_pointer_reg(sp), .res(res));
    // =========================================
    // Helpers
    task automatic check(input string w, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", w, exp, seen);
        end
    endtask
    task automatic exp_res(input string w, input logic [1:0] t, input logic [15:0] a, input logic f);
        check({w, " vld"}, 16'(res.valid), 16'h0001);
        check({w, " tgt"}, 16'(res.target), 16'(t));
        check({w, " addr"}, res.addr, a);
        check({w, " flt"}, 16'(res.fault), 16'(f));
    endtask
    // Spare cycle after a load so no request edge sees a half-written pair
    task automatic load(input logic [1:0] s, input logic [15:0] v);
        wsel = s;
        wdata = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic go(input oag_pkg::mode_t m);
        req.mode = m;
        req_valid = 1'b1;
        @(negedge clk);
    endtask
    // =========================================
    // Scenarios
    task automatic t_direct();
        req.full_address_field = 16'h1234;
        go(oag_pkg::MODE_DIRECT);
        exp_res("dir", oag_pkg::TGT_RAM, 16'h1234, 1'b0);
        req.full_address_field = 16'hFF80;
        go(oag_pkg::MODE_DIRECT);
        exp_res("dir sfr", oag_pkg::TGT_SFR, 16'hFF80, 1'b0);
        $display("direct done");
    endtask
    task automatic t_short();
        logic [7:0] b [4] = '{8'h20, 8'hFF, 8'h00, 8'h1F};
        foreach (b[i]) begin
            req.byte_field = b[i];
            go(oag_pkg::MODE_SHORT);
            exp_res("short", b[i] < 8'h20 ? oag_pkg::TGT_SFR : oag_pkg::TGT_RAM,
                {b[i] < 8'h20 ? 8'hFF : 8'hFE, b[i]}, 1'b0);
        end
        req.wide = 1'b1;
        req.byte_field = 8'h22;
        go(oag_pkg::MODE_SHORT);
        exp_res("short even", oag_pkg::TGT_RAM, 16'hFE22, 1'b0);
        check("short wide", 16'(res.wide), 16'h0001);
        req.byte_field = 8'h21;
        go(oag_pkg::MODE_SHORT);
        exp_res("short odd", oag_pkg::TGT_RAM, 16'hFE21, 1'b1);
        req.wide = 1'b0;
        $display("short done");
    endtask
    task automatic t_sfr();
        logic [7:0] b [6] = '{8'h00, 8'hCF, 8'hE0, 8'hFF, 8'hD0, 8'hDF};
        foreach (b[i]) begin
            req.byte_field = b[i];
            go(oag_pkg::MODE_SFR);
            check("sfr tgt", 16'(res.target), 16'(i < 4 ? oag_pkg::TGT_SFR : oag_pkg::TGT_NONE));
            check("sfr flt", 16'(res.fault), 16'(i > 3));
            if (i < 4) check("sfr addr", res.addr, {8'hFF, b[i]});
        end
        $display("sfr done");
    endtask
    task automatic t_reg();
        for (int i = 0; i < 8; i++) begin
            req.reg_code = 3'(i);
            req.register_pair_select = 2'(i);
            go(oag_pkg::MODE_REG8);
            check("r8 tgt", 16'(res.target), 16'(oag_pkg::TGT_REG));
            check("r8 sel", 16'(res.reg_sel), 16'(i));
            check("r8 wide", 16'(res.wide), 16'h0000);
            if (i < 4) begin
                go(oag_pkg::MODE_REG16);
                check("r16 sel", 16'(res.pair_sel), 16'(i));
                check("r16 wide", 16'(res.wide), 16'h0001);
                check("r16 tgt", 16'(res.target), 16'(oag_pkg::TGT_REG));
            end
        end
        $display("reg done");
    endtask
    task automatic t_pointer();
        load(2'h0, 16'hFF05);
        load(2'h1, 16'hFFF0);
        req.indirect_sel = 1'b0;
        go(oag_pkg::MODE_INDIRECT);
        exp_res("ind1", oag_pkg::TGT_SFR, 16'hFF05, 1'b0);
        req.indirect_sel = 1'b1;
        go(oag_pkg::MODE_INDIRECT);
        exp_res("ind2", oag_pkg::TGT_SFR, 16'hFFF0, 1'b0);
        req.byte_field = 8'h8F;
        go(oag_pkg::MODE_BASED);
        exp_res("based", oag_pkg::TGT_RAM, 16'h007F, 1'b0);
        $display("pointer done");
    endtask
    task automatic t_stack();
        logic [15:0] s [4] = '{16'hFE20, 16'hFEFF, 16'hFE1F, 16'hFF00};
        foreach (s[i]) begin
            load(2'h2, s[i]);
            go(oag_pkg::MODE_STACK);
            check("stk tgt", 16'(res.target), 16'(i < 2 ? oag_pkg::TGT_RAM : oag_pkg::TGT_NONE));
            check("stk flt", 16'(res.fault), 16'(i > 1));
            if (i < 2) check("stk addr", res.addr, s[i]);
        end
        $display("stack done");
    endtask
    // =========================================
    // Run control
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        t_direct();
        t_short();
        t_sfr();
        t_reg();
        t_pointer();
        t_stack();
        req_valid = 1'b0;
        @(negedge clk);
        check("idle vld", 16'(res.valid), 16'h0000);
        finish_test();
    end
    // Tests need about 53 cycles
    initial begin
        #(40 * 2000);
        error_cnt++;
        finish_test();
    end
endmodule // operand_address_generator_bench
`default_nettype wire
